// ---- hdl/cscc_core.sv ----
// CPU status word and core control word with a Wishbone slave port.
`default_nettype none
`include "cscc_params.svh"
// Overview of operation
// RQ1: Status bits 7-5 hold three-bit priority level.
// RQ2: Control msb joins status bits into level.
// RQ3: Nesting disable makes priority bits read-only.
// RQ4: Status bit 4 shows repeat loop busy.
// RQ5: Status bit 3 follows negative result.
// RQ6: Status bit 2 follows signed overflow.
// RQ7: Zero flag set by zero, cleared otherwise.
// RQ8: Status bit 0 follows carry out.
// RQ9: Status writes change clip stickies, combined clears.
// RQ10: Control bits 13-12 choose multiply signedness.
// RQ11: Control bit 5 clips data space writes.
// RQ12: Separate accumulator clip enables, width select.
// RQ13: Control bits 10-8 report do-loop depth.
module cscc_core #(
  parameter int DEPTH_W = 3  // Width of the do-loop depth count.
) (
  input  wire logic                      i_clock,
  input  wire logic                      i_reset_n,
  // Wishbone classic slave.
  input  wire logic                      i_wb_cyc,
  input  wire logic                      i_wb_stb,
  input  wire logic                      i_wb_we,
  input  wire logic [3:0]                i_wb_adr,
  input  wire logic [3:0]                i_wb_sel,
  input  wire logic [31:0]               i_wb_dat,
  output logic [31:0]                    o_wb_dat,
  output logic                           o_wb_ack,
  // Core side.
  input  wire cscc_pkg::cscc_alu_flags_t i_alu,
  input  wire logic                      i_repeat_busy,
  input  wire logic [DEPTH_W-1:0]        i_do_depth,
  input  wire logic                      i_clip_a_event,
  input  wire logic                      i_clip_b_event,
  input  wire logic                      i_prio_load,
  input  wire logic [3:0]                i_prio_value,
  output logic [3:0]                     o_priority_level,
  output logic                           o_user_irq_disabled,
  output cscc_pkg::cscc_sat_cfg_t        o_sat_cfg
);
  // ==========================================================
  // Helper functions

  // Merges write data into a 16-bit register under byte lanes.
  // Lane 0 carries bits 7:0 and lane 1 bits 15:8; a lane left out
  // keeps the old bits, so software may touch one byte alone.
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [1:0]  sel);
    logic [15:0] res;
    res = old_v;
    if (sel[0]) begin
      res[7:0] = new_v[7:0];
    end
    if (sel[1]) begin
      res[15:8] = new_v[15:8];
    end
    return res;
  endfunction

  // ==========================================================
  // Bus handshake
  cscc_pkg::cscc_bus_state_t state_r;   // Bus state.
  cscc_pkg::cscc_bus_state_t state_nxt; // Next bus state.
  logic                      req;       // New request seen.
  logic                      wr_stb;    // Write takes effect.
  logic                      hit_st;    // Status word addressed.
  logic                      hit_cc;    // Control word addressed.
  logic                      hit_ns;    // Nesting control addressed.

  assign req    = i_wb_cyc && i_wb_stb && (state_r == cscc_pkg::CSCC_IDLE);
  assign wr_stb = req && i_wb_we;
  assign hit_st = (i_wb_adr == `CSCC_OFF_STATUS);
  assign hit_cc = (i_wb_adr == `CSCC_OFF_CONTROL);
  assign hit_ns = (i_wb_adr == `CSCC_OFF_NESTING);

  // Answers each request one cycle later, then drops ack.
  // The write lands on the edge that takes the request, one cycle
  // before the master sees ack. Taking no request in the ack cycle keeps
  // a strobe that is still held while ack is high from being taken
  // a second time.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      cscc_pkg::CSCC_IDLE: begin
        if (req) begin
          state_nxt = cscc_pkg::CSCC_ACK;
        end
      end
      cscc_pkg::CSCC_ACK: begin
        state_nxt = cscc_pkg::CSCC_IDLE;
      end
      default: begin
        state_nxt = cscc_pkg::CSCC_IDLE;
      end
    endcase
  end

  // Registers the bus state.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= cscc_pkg::CSCC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_wb_ack = (state_r == cscc_pkg::CSCC_ACK);

  // ==========================================================
  // Status word (priority, clip stickies) and nesting disable
  logic [2:0]  prio_r;      // Three-bit priority level.
  logic [2:0]  prio_nxt;
  logic        clip_a_r;    // Accumulator A clip sticky.
  logic        clip_a_nxt;
  logic        clip_b_r;    // Accumulator B clip sticky.
  logic        clip_b_nxt;
  logic        nest_dis_r;  // Interrupt nesting disable.
  logic        nest_dis_nxt;
  logic [15:0] st_wr;       // Status write image after lanes.
  logic [15:0] st_cur;      // Current status word.
  logic [3:0]  alu_flags;   // Flags from the flag module.

  // Computes next priority, stickies and nesting disable.
  // Writes merge into the live status image, so a write to one lane
  // leaves the other lane's fields as they are. The nesting disable
  // freezes the priority against software and against the core's own
  // loads alike; the flags, the stickies and the repeat bit are
  // unaffected by it.
  always_comb begin
    prio_nxt     = prio_r;
    clip_a_nxt   = clip_a_r;
    clip_b_nxt   = clip_b_r;
    nest_dis_nxt = nest_dis_r;
    st_wr        = lane_merge(st_cur, i_wb_dat[15:0], i_wb_sel[1:0]);
    if (wr_stb && hit_st) begin
      // Priority bits ignore writes while nesting is disabled.
      if (!nest_dis_r) begin
        prio_nxt = st_wr[`CSCC_ST_PRIO_HI:`CSCC_ST_PRIO_LO]; // [RQ3]
      end
      // Stickies take written values; clearing the combined bit
      // clears both.
      clip_a_nxt = st_wr[`CSCC_ST_CLIP_A]; // [RQ9]
      clip_b_nxt = st_wr[`CSCC_ST_CLIP_B]; // [RQ9]
      if (i_wb_sel[1] && !st_wr[`CSCC_ST_CLIP_AB]) begin
        clip_a_nxt = 1'b0; // [RQ9]
        clip_b_nxt = 1'b0; // [RQ9]
      end
    end
    if (wr_stb && hit_ns && i_wb_sel[0]) begin
      nest_dis_nxt = i_wb_dat[0];
    end
    // Core exception logic may load the priority directly.
    // Only the low three bits are loaded; the level msb lives in the
    // control word and is changed by software alone.
    if (i_prio_load && !nest_dis_r) begin
      prio_nxt = i_prio_value[2:0]; // [RQ1] [RQ3]
    end
    // A clip event wins over a software clear in the same cycle.
    if (i_clip_a_event) begin
      clip_a_nxt = 1'b1;
    end
    if (i_clip_b_event) begin
      clip_b_nxt = 1'b1;
    end
  end

  // Registers status state.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prio_r     <= 3'h0;
      clip_a_r   <= 1'b0;
      clip_b_r   <= 1'b0;
      nest_dis_r <= 1'b0;
    end else begin
      prio_r     <= prio_nxt;
      clip_a_r   <= clip_a_nxt;
      clip_b_r   <= clip_b_nxt;
      nest_dis_r <= nest_dis_nxt;
    end
  end

  // ALU flags, software-writable, ALU update takes priority.
  cscc_flags u_flags (
    .i_clock    (i_clock),
    .i_reset_n  (i_reset_n),
    .i_alu      (i_alu),
    .i_sw_we    (wr_stb && hit_st && i_wb_sel[0]),
    .i_sw_flags (st_wr[3:0]),
    .o_flags    (alu_flags)
  );

  // Assembles the status word.
  // The combined sticky is not stored: it reads as the OR of the two
  // accumulator stickies, so it can never disagree with them.
  always_comb begin
    st_cur = 16'h0000;
    st_cur[`CSCC_ST_PRIO_HI:`CSCC_ST_PRIO_LO] = prio_r; // [RQ1]
    st_cur[`CSCC_ST_REPEAT] = i_repeat_busy;           // [RQ4]
    st_cur[3:0] = alu_flags;
    st_cur[`CSCC_ST_CLIP_A] = clip_a_r;
    st_cur[`CSCC_ST_CLIP_B] = clip_b_r;
    st_cur[`CSCC_ST_CLIP_AB] = clip_a_r | clip_b_r;     // [RQ9]
  end

  // ==========================================================
  // Core control word
  logic [15:0] cc_r;    // Writable control bits.
  logic [15:0] cc_nxt;
  logic [15:0] cc_cur;  // Readback with live depth.

  // Applies software writes to the writable control bits.
  // The mask keeps the depth field, the unused bits and the low three
  // bits at zero in the stored word; the depth is never stored here but
  // inserted live at readback, so it cannot go stale.
  always_comb begin
    cc_nxt = cc_r;
    if (wr_stb && hit_cc) begin
      cc_nxt = lane_merge(cc_r, i_wb_dat[15:0], i_wb_sel[1:0])
               & `CSCC_CONTROL_WMASK;
    end
  end

  // Registers the control bits.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cc_r <= `CSCC_CONTROL_RST;
    end else begin
      cc_r <= cc_nxt;
    end
  end

  // Readback inserts the live do-loop depth.
  always_comb begin
    cc_cur = cc_r;
    cc_cur[`CSCC_CC_DEPTH_HI:`CSCC_CC_DEPTH_LO] = i_do_depth[2:0]; // [RQ13]
  end

  // ==========================================================
  // Outputs to the core
  logic [3:0] level;  // Four-bit priority level.
  assign level = {cc_r[`CSCC_CC_PRIO_MSB], prio_r}; // [RQ2]

  // Drives priority and saturation settings from flip-flops.
  // These copies trail the registers by one cycle. The interrupt logic
  // and the DSP engine therefore see a new setting on the cycle after
  // the write lands, which keeps long paths off the register outputs.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_priority_level    <= 4'h0;
      o_user_irq_disabled <= 1'b0;
      o_sat_cfg           <= '0;
    end else begin
      o_priority_level    <= level; // [RQ2]
      // Level 7, or any level with the msb set, masks user interrupts.
      o_user_irq_disabled <= level[3] || (prio_r == 3'h7); // [RQ1] [RQ2]
      o_sat_cfg.acc_a_en  <= cc_r[`CSCC_CC_A_CLIP];        // [RQ12]
      o_sat_cfg.acc_b_en  <= cc_r[`CSCC_CC_B_CLIP];        // [RQ12]
      o_sat_cfg.wide_mode <= cc_r[`CSCC_CC_CLIP_WIDTH];    // [RQ12]
      o_sat_cfg.dw_en     <= cc_r[`CSCC_CC_DW_CLIP];       // [RQ11]
      // Only code 01 selects unsigned; code 10 and the reserved code 11
      // both leave the multiplier signed, so no code is left undefined.
      o_sat_cfg.mul_unsigned <= // [RQ10]
        (cc_r[`CSCC_CC_SIGN_HI:`CSCC_CC_SIGN_LO] == `CSCC_SIGN_UNSIGNED);
    end
  end

  // ==========================================================
  // Read data
  logic [31:0] rd_r;   // Registered read data.
  logic [31:0] rd_nxt;

  // Selects read data; unmapped addresses read zero.
  // The word is captured on the edge that takes the request, so live
  // fields (repeat busy, loop depth, flags) read as they stood then.
  // Only lanes 0 and 1 and the low half of the bus are in use; the
  // upper half reads zero and the upper lanes are ignored on writes.
  always_comb begin
    rd_nxt = rd_r;
    if (req) begin
      rd_nxt = 32'h0000_0000;
      if (hit_st) begin
        rd_nxt[15:0] = st_cur;
      end else if (hit_cc) begin
        rd_nxt[15:0] = cc_cur;
      end else if (hit_ns) begin
        rd_nxt[0] = nest_dis_r;
      end
    end
  end

  // Registers read data.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_r <= 32'h0000_0000;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign o_wb_dat = rd_r;
endmodule
`default_nettype wire

// ---- hdl/cscc_params.svh ----
// Offsets, field positions, reset values and codes for the status/control block.
`ifndef CSCC_PARAMS_SVH
`define CSCC_PARAMS_SVH

// Register byte addresses on the Wishbone bus.
`define CSCC_OFF_STATUS      4'h0
`define CSCC_OFF_CONTROL     4'h4
`define CSCC_OFF_NESTING     4'h8

// Status word field positions.
`define CSCC_ST_CARRY        0
`define CSCC_ST_ZERO         1
`define CSCC_ST_WRAP         2
`define CSCC_ST_NEG          3
`define CSCC_ST_REPEAT       4
`define CSCC_ST_PRIO_LO      5
`define CSCC_ST_PRIO_HI      7
`define CSCC_ST_CLIP_AB      13
`define CSCC_ST_CLIP_B       14
`define CSCC_ST_CLIP_A       15

// Control word field positions.
`define CSCC_CC_PRIO_MSB     3
`define CSCC_CC_CLIP_WIDTH   4
`define CSCC_CC_DW_CLIP      5
`define CSCC_CC_B_CLIP       6
`define CSCC_CC_A_CLIP       7
`define CSCC_CC_DEPTH_LO     8
`define CSCC_CC_DEPTH_HI     10
`define CSCC_CC_SIGN_LO      12
`define CSCC_CC_SIGN_HI      13

// Reset values and writable masks.
`define CSCC_STATUS_RST      16'h0000
`define CSCC_CONTROL_RST     16'h0020
`define CSCC_CONTROL_WMASK   16'h30f8

// Multiply sign mode encodings.
`define CSCC_SIGN_SIGNED     2'h0
`define CSCC_SIGN_UNSIGNED   2'h1
`define CSCC_SIGN_RESERVED   2'h3

`endif

// ---- hdl/cscc_pkg.sv ----
// Types shared by the status/control block and its flag logic.
`default_nettype none
package cscc_pkg;
  // Arithmetic flag update from the ALU.
  typedef struct packed {
    logic        valid;  // Flag update this cycle.
    logic        neg;    // Result negative.
    logic        wrap;   // Signed overflow.
    logic        zero_en; // Operation affects the zero flag.
    logic        zero;   // Result was zero.
    logic        carry;  // Carry out of the top bit.
  } cscc_alu_flags_t;

  // Saturation settings handed to the DSP engine.
  typedef struct packed {
    logic        acc_a_en;  // Accumulator A clipping on.
    logic        acc_b_en;  // Accumulator B clipping on.
    logic        wide_mode; // One for 9.31, zero for 1.31.
    logic        dw_en;     // Data space write clipping on.
    logic        mul_unsigned; // Multiplies are unsigned.
  } cscc_sat_cfg_t;

  // Bus state machine with one-hot codes.
  typedef enum logic [1:0] {
    CSCC_IDLE = 2'b01,
    CSCC_ACK  = 2'b10
  } cscc_bus_state_t;
endpackage
`default_nettype wire

// ---- hdl/cscc_flags.sv ----
// Arithmetic flag register for the ALU result flags.
`default_nettype none
`include "cscc_params.svh"
module cscc_flags (
  input  wire logic                     i_clock,
  input  wire logic                     i_reset_n,
  input  wire cscc_pkg::cscc_alu_flags_t i_alu,
  input  wire logic                     i_sw_we,
  input  wire logic [3:0]               i_sw_flags,
  output logic [3:0]                    o_flags
);
  // ==========================================================
  // Flag state
  logic [3:0] flags_r;   // Negative, wrap, zero, carry.
  logic [3:0] flags_nxt; // Next flag values.

  // The ALU wins over software when both hit the same cycle.
  always_comb begin
    flags_nxt = flags_r;
    if (i_sw_we) begin
      flags_nxt = i_sw_flags;
    end
    if (i_alu.valid) begin
      flags_nxt[`CSCC_ST_NEG]   = i_alu.neg;    // [RQ5]
      flags_nxt[`CSCC_ST_WRAP]  = i_alu.wrap;   // [RQ6]
      flags_nxt[`CSCC_ST_CARRY] = i_alu.carry;  // [RQ8]
      // Zero follows only operations that affect it.
      if (i_alu.zero_en) begin
        flags_nxt[`CSCC_ST_ZERO] = i_alu.zero;  // [RQ7]
      end
    end
  end

  // Registers the flags.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flags_r <= 4'h0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign o_flags = flags_r;
endmodule
`default_nettype wire

// ---- test/cscc_core_asserts.sv ----
// Port checker for the status and control word block.
`default_nettype none
module cscc_core_asserts #(
  parameter int DEPTH_W = 3  // Do-loop depth width.
) (
  input wire logic                      i_clock,
  input wire logic                      i_reset_n,
  input wire logic                      i_wb_cyc,
  input wire logic                      i_wb_stb,
  input wire logic                      i_wb_we,
  input wire logic [3:0]                i_wb_adr,
  input wire logic [3:0]                i_wb_sel,
  input wire logic [31:0]               i_wb_dat,
  input wire logic [31:0]               o_wb_dat,
  input wire logic                      o_wb_ack,
  input wire cscc_pkg::cscc_alu_flags_t i_alu,
  input wire logic                      i_repeat_busy,
  input wire logic [DEPTH_W-1:0]        i_do_depth,
  input wire logic                      i_clip_a_event,
  input wire logic                      i_clip_b_event,
  input wire logic                      i_prio_load,
  input wire logic [3:0]                i_prio_value,
  input wire logic [3:0]                o_priority_level,
  input wire logic                      o_user_irq_disabled,
  input wire cscc_pkg::cscc_sat_cfg_t   o_sat_cfg
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // ==========================================================
  // Helpers: control writes per lane and write data two back.
  logic        cw_lo;
  logic        cw_hi;
  logic        rd_ack;
  logic [31:0] dat_q;
  logic [31:0] dat_qq;
  assign cw_lo = o_wb_ack && i_wb_we && i_wb_adr == 4'h4 && i_wb_sel[0];
  assign cw_hi = o_wb_ack && i_wb_we && i_wb_adr == 4'h4 && i_wb_sel[1];
  assign rd_ack = o_wb_ack && !i_wb_we;
  // Delays write data so it lines up with the settled outputs.
  always_ff @(posedge i_clock) begin
    dat_q  <= i_wb_dat;
    dat_qq <= dat_q;
  end
  // ==========================================================
  // Assertions.
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack lasted more than one cycle");
  a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=>
    o_wb_ack)
    else $error("request not answered in the next cycle");
  a_irq_disable: assert property (o_user_irq_disabled ==
    (o_priority_level[3] || o_priority_level[2:0] == 3'h7))
    else $error("user interrupt disable does not match level");
  a_clip_fields: assert property (cw_lo |-> ##2
    {o_sat_cfg.acc_a_en, o_sat_cfg.acc_b_en, o_sat_cfg.wide_mode,
     o_sat_cfg.dw_en} == {dat_qq[7], dat_qq[6], dat_qq[4], dat_qq[5]})
    else $error("saturation settings differ from control write");
  a_prio_msb: assert property (cw_lo |-> ##2
    o_priority_level[3] == dat_qq[3])
    else $error("priority msb differs from control write");
  a_sign_mode: assert property (cw_hi |-> ##2
    o_sat_cfg.mul_unsigned == (dat_qq[13:12] == 2'h1))
    else $error("multiply sign mode wrong");
  a_depth_read: assert property (rd_ack && i_wb_adr == 4'h4 |->
    o_wb_dat[10:8] == $past(i_do_depth))
    else $error("do-loop depth read wrong");
  a_repeat_read: assert property (rd_ack && i_wb_adr == 4'h0 |->
    o_wb_dat[4] == $past(i_repeat_busy))
    else $error("repeat busy read wrong");
  a_ctrl_fixed: assert property (rd_ack && i_wb_adr == 4'h4 |->
    (o_wb_dat & 32'hffffc807) == 32'h00000000)
    else $error("control read shows unused bits");
  a_unmapped_zero: assert property (rd_ack && i_wb_adr != 4'h0 &&
    i_wb_adr != 4'h4 && i_wb_adr != 4'h8 |-> o_wb_dat == 32'h00000000)
    else $error("unmapped read not zero");
  c_ctrl_lo: cover property (cw_lo);
  c_ctrl_hi: cover property (cw_hi);
  c_disabled: cover property (o_user_irq_disabled);
endmodule
`default_nettype wire

// ---- test/cscc_partner.sv ----
// Model of the ALU, DSP engine and loop sequencer beside the block.
`default_nettype none
module cscc_partner (
  input  wire logic                 i_clock,
  output cscc_pkg::cscc_alu_flags_t o_alu,
  output logic                      o_repeat_busy,
  output logic [2:0]                o_do_depth,
  output logic                      o_clip_a,
  output logic                      o_clip_b,
  output logic                      o_prio_load,
  output logic [3:0]                o_prio_value
);
  // Everything idles low until a task asks for activity.
  initial begin
    o_alu = '0;
    {o_repeat_busy, o_do_depth, o_clip_a, o_clip_b} = 6'h00;
    {o_prio_load, o_prio_value} = 5'h00;
  end
  // One-cycle flag update: {neg, wrap, zero_en, zero, carry}.
  task automatic alu(input logic [4:0] f);
    o_alu <= {1'h1, f};
    @(posedge i_clock);
    o_alu <= '0;
  endtask
  // Loop state levels change only just after an edge.
  task automatic loops(input logic b, input logic [2:0] d);
    o_repeat_busy <= b;
    o_do_depth    <= d;
  endtask
  // One-cycle saturation events from the DSP engine.
  task automatic clip(input logic a, input logic b);
    {o_clip_a, o_clip_b} <= {a, b};
    @(posedge i_clock);
    {o_clip_a, o_clip_b} <= 2'h0;
  endtask
  // One-cycle priority load from exception processing.
  task automatic prio(input logic [3:0] v);
    {o_prio_load, o_prio_value} <= {1'h1, v};
    @(posedge i_clock);
    o_prio_load <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ---- test/cscc_core_test.sv ----
// Bench for the status and control word block.
`default_nettype none
module cscc_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock, i_reset_n, cyc, stb, we, rb, cla, clb, pld, irqd, ack;
  logic [3:0] adr, sel, pv, lvl;
  logic [31:0] dat, rdat_w;
  logic [2:0] dep;
  logic [15:0] rdat;
  logic z;
  cscc_pkg::cscc_alu_flags_t alu;
  cscc_pkg::cscc_sat_cfg_t sat;
  int bad_count, checked, cycles;
  logic [4:0] ops [5] = '{5'h11, 5'h0e, 5'h00, 5'h04, 5'h1f};
  cscc_partner i_cscc_partner (.i_clock(i_clock), .o_alu(alu),
    .o_repeat_busy(rb), .o_do_depth(dep), .o_clip_a(cla), .o_clip_b(clb),
    .o_prio_load(pld), .o_prio_value(pv));
  cscc_core #(.DEPTH_W(3)) i_cscc_core (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat_w),
    .o_wb_ack(ack), .i_alu(alu), .i_repeat_busy(rb), .i_do_depth(dep),
    .i_clip_a_event(cla), .i_clip_b_event(clb), .i_prio_load(pld),
    .i_prio_value(pv), .o_priority_level(lvl),
    .o_user_irq_disabled(irqd), .o_sat_cfg(sat));
  // ==========================================================
  // Clock, and a ceiling on run length.
  initial begin
    i_clock = 1'h0;
    forever #10 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      results();
    end
  end
  // ==========================================================
  // Compare, bus and closing tasks.
  task automatic cmp(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // One classic Wishbone cycle, held until ack is sampled.
  task automatic go(input logic w, input logic [3:0] a,
                    input logic [15:0] v, input logic [3:0] s);
    {cyc, stb, we, adr, sel, dat} <= {2'h3, w, a, s, 16'h0000, v};
    do @(posedge i_clock); while (ack !== 1'h1);
    rdat = rdat_w[15:0];
    {cyc, stb, we} <= 3'h0;
    @(posedge i_clock);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] m,
                     input logic [15:0] e, input string n);
    go(1'h0, a, 16'h0000, 4'h3);
    cmp(n, e, rdat & m);
  endtask
  task automatic results();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    {i_reset_n, cyc, stb, we, adr, sel, dat, z} = '0;
    {bad_count, checked, cycles} = '0;
    repeat (6) @(posedge i_clock);
    i_reset_n <= 1'h1;
    @(posedge i_clock);
    rdc(4'h0, 16'hffff, 16'h0000, "status reset");
    rdc(4'h4, 16'hffff, 16'h0020, "control reset");
    cmp("satcfg reset", 16'h0002, {11'h000, sat});
    // ALU flag updates; the zero flag only moves when enabled.
    for (int k = 0; k < 5; k++) begin
      z = ops[k][2] ? ops[k][1] : z;
      i_cscc_partner.alu(ops[k]);
      rdc(4'h0, 16'h000f, {12'h000, ops[k][4:3], z, ops[k][0]},
          "flags");
    end
    // Repeat busy and loop depth shown live.
    for (int k = 0; k < 2; k++) begin
      i_cscc_partner.loops(k == 0, k ? 3'h7 : 3'h5);
      @(posedge i_clock);
      rdc(4'h0, 16'h0010, {11'h000, k == 0, 4'h0}, "repeat");
      rdc(4'h4, 16'h0700, {5'h00, k ? 3'h7 : 3'h5, 8'h00}, "depth");
    end
    // Priority level from status bits and control msb.
    for (int k = 0; k < 3; k++) begin
      go(1'h1, 4'h0, {8'h00, k ? 3'h3 : 3'h7, 5'h00}, 4'h1);
      go(1'h1, 4'h4, {8'h00, 4'h2, k == 1, 3'h0}, 4'h1);
      @(posedge i_clock);
      cmp("level", {12'h000, k == 1, k ? 3'h3 : 3'h7},
          {12'h000, lvl});
      cmp("disabled", {15'h0000, k < 2}, {15'h0000, irqd});
    end
    // Nesting disable freezes the priority bits against all writers.
    go(1'h1, 4'h8, 16'h0001, 4'h1);
    rdc(4'h8, 16'hffff, 16'h0001, "nest read");
    go(1'h1, 4'h0, 16'h00a0, 4'h1);
    i_cscc_partner.prio(4'h6);
    rdc(4'h0, 16'h00e0, 16'h0060, "prio frozen");
    go(1'h1, 4'h8, 16'h0000, 4'h1);
    i_cscc_partner.prio(4'h6);
    rdc(4'h0, 16'h00e0, 16'h00c0, "prio load");
    // Every multiply sign code.
    for (int c = 0; c < 4; c++) begin
      go(1'h1, 4'h4, {2'h0, c[1:0], 12'h020}, 4'h3);
      @(posedge i_clock);
      cmp("unsigned", {15'h0000, c == 1},
          {15'h0000, sat.mul_unsigned});
      rdc(4'h4, 16'h3000, {2'h0, c[1:0], 12'h000}, "sign code");
    end
    // Accumulator and data write saturation enables, both widths.
    for (int k = 0; k < 2; k++) begin
      go(1'h1, 4'h4, k ? 16'h0020 : 16'h00d0, 4'h1);
      @(posedge i_clock);
      cmp("satcfg", k ? 16'h0002 : 16'h001c, {11'h000, sat});
    end
    // Clip stickies set by events, cleared through the combined bit.
    i_cscc_partner.clip(1'h1, 1'h0);
    rdc(4'h0, 16'he000, 16'ha000, "sticky a");
    i_cscc_partner.clip(1'h0, 1'h1);
    rdc(4'h0, 16'he000, 16'he000, "sticky ab");
    go(1'h1, 4'h0, 16'h0000, 4'h2);
    rdc(4'h0, 16'he000, 16'h0000, "sticky clear");
    go(1'h1, 4'h0, 16'h6000, 4'h2);
    rdc(4'h0, 16'he000, 16'h6000, "sticky direct");
    // Unmapped place reads zero and ignores writes.
    go(1'h1, 4'hc, 16'hffff, 4'h3);
    rdc(4'hc, 16'hffff, 16'h0000, "unmapped");
    rdc(4'h4, 16'h30f8, 16'h3020, "control kept");
    results();
  end
endmodule
bind cscc_core cscc_core_asserts #(.DEPTH_W(DEPTH_W)) i_cscc_core_asserts (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .i_alu(i_alu), .i_repeat_busy(i_repeat_busy),
  .i_do_depth(i_do_depth), .i_clip_a_event(i_clip_a_event),
  .i_clip_b_event(i_clip_b_event), .i_prio_load(i_prio_load),
  .i_prio_value(i_prio_value), .o_priority_level(o_priority_level),
  .o_user_irq_disabled(o_user_irq_disabled), .o_sat_cfg(o_sat_cfg));
`default_nettype wire
